// ==== verilog/csprg_pkg.sv ====
// constants for the core status and pointer register block
package csprg_pkg;
  localparam logic [7:0] CSPRG_ADDR_SP = 8'h81;
  localparam logic [7:0] CSPRG_ADDR_DPL = 8'h82;
  localparam logic [7:0] CSPRG_ADDR_DPH = 8'h83;
  localparam logic [7:0] CSPRG_ADDR_PSW = 8'hD0;
  localparam logic [7:0] CSPRG_ADDR_ACC = 8'hE0;
  localparam logic [7:0] CSPRG_ADDR_B = 8'hF0;
  localparam logic [7:0] CSPRG_SP_RST = 8'h07;
  localparam logic [7:0] CSPRG_ZERO_RST = 8'h00;
  localparam logic [7:0] CSPRG_ONE = 8'h01;
  localparam logic [15:0] CSPRG_PTR_ONE = 16'h0001;
  // status word field positions
  localparam int CSPRG_CY_BIT = 7;
  localparam int CSPRG_AC_BIT = 6;
  localparam int CSPRG_F0_BIT = 5;
  localparam int CSPRG_RS_HI = 4;
  localparam int CSPRG_RS_LO = 3;
  localparam int CSPRG_OV_BIT = 2;
  localparam int CSPRG_F1_BIT = 1;
  localparam int CSPRG_PAR_BIT = 0;
  localparam int CSPRG_BANK_IDX_W = 3;
endpackage

// ==== verilog/csprg_regs.sv ====
// core special registers: stack pointer, indirect pointer, status word, accumulators
`timescale 1ns/1ps

// Function
// - reset loads stack pointer with 0x07 and clears every other register here
// - a push increments the stack pointer first, then writes at the new location
// - indirect pointer is 16 bits, high pointer byte over low pointer byte
// - status bit 7 carry set on add carry or subtract borrow, else cleared
// - status bit 6 half carry set on nibble carry or borrow, else cleared
// - status bits 4-3 pick working bank at 0x00, 0x08, 0x10 or 0x18
// - status bit 2 overflow set on carry, borrow or multiply/divide overflow
// - status bit 0 is the even parity of the accumulator, one for an odd count of ones
// - status bits 5 and 1 are user flags the block never changes itself
// - primary working register is the bit addressable accumulator, reset zero
// - secondary working register is bit addressable second accumulator, reset zero
module csprg_regs (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // special register byte port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_rd_hit,
  // bit port
  input wire logic i_bit_wr,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wdata,
  // execution updates
  input wire logic i_push,
  input wire logic [7:0] i_push_data,
  input wire logic i_pop,
  input wire logic i_ptr_inc,
  input wire logic i_arith_upd,
  input wire logic i_arith_cy,
  input wire logic i_arith_ac,
  input wire logic i_arith_ov,
  input wire logic i_acc_we,
  input wire logic [7:0] i_acc_data,
  input wire logic i_b_we,
  input wire logic [7:0] i_b_data,
  input wire logic [csprg_pkg::CSPRG_BANK_IDX_W-1:0] i_reg_idx,
  // stack write toward internal ram
  output logic o_stack_wr,
  output logic [7:0] o_stack_addr,
  output logic [7:0] o_stack_data,
  // state views
  output logic [7:0] o_stack_top_pointer,
  output logic [15:0] o_indirect_pointer,
  output logic [7:0] o_processor_status_word,
  output logic [7:0] o_primary_working_reg,
  output logic [7:0] o_secondary_working_reg,
  output logic [7:0] o_reg_addr
);
  import csprg_pkg::*;
  logic [7:0] sp_r, dpl_r, dph_r, acc_r, b_r;
  logic cy_r, ac_r, ov_r, f0_r, f1_r;
  logic [1:0] rs_r;
  logic [7:0] psw_view;
  logic [8:0] m_sp, m_dpl, m_dph, m_psw, m_acc, m_b;
  logic [15:0] ptr_inc_val;
  // ----------------------------------------
  // write merge
  // ----------------------------------------
  // byte write or single bit write; returns {hit, new value}
  function automatic logic [8:0] merge(input logic [7:0] cur, input logic [7:0] base,
                                       input logic bit_able);
    logic [7:0] v;
    logic hit;
    v = cur;
    hit = 1'b0;
    if (i_sfr_wr && i_sfr_addr == base) begin
      v = i_sfr_wdata;
      hit = 1'b1;
    end else if (bit_able && i_bit_wr && i_bit_addr[7:3] == base[7:3]) begin
      v[i_bit_addr[2:0]] = i_bit_wdata;
      hit = 1'b1;
    end
    merge = {hit, v};
  endfunction
  // merge reads the strobes itself, so only a process re-runs when they move
  always_comb begin
    m_sp = merge(sp_r, CSPRG_ADDR_SP, 1'b0);
    m_dpl = merge(dpl_r, CSPRG_ADDR_DPL, 1'b0);
    m_dph = merge(dph_r, CSPRG_ADDR_DPH, 1'b0);
    m_psw = merge(psw_view, CSPRG_ADDR_PSW, 1'b1);
    m_acc = merge(acc_r, CSPRG_ADDR_ACC, 1'b1);
    m_b = merge(b_r, CSPRG_ADDR_B, 1'b1);
  end
  assign ptr_inc_val = {dph_r, dpl_r} + CSPRG_PTR_ONE;
  // ----------------------------------------
  // stack pointer
  // ----------------------------------------
  // push and pop beat a software write in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sp_r <= CSPRG_SP_RST;
    end else if (i_push) begin
      sp_r <= sp_r + CSPRG_ONE;
    end else if (i_pop) begin
      sp_r <= sp_r - CSPRG_ONE;
    end else if (m_sp[8]) begin
      sp_r <= m_sp[7:0];
    end
  end
  // stack byte lands one cycle after the push, at the already bumped pointer
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_stack_wr <= 1'b0;
      o_stack_addr <= CSPRG_ZERO_RST;
      o_stack_data <= CSPRG_ZERO_RST;
    end else begin
      o_stack_wr <= i_push;
      if (i_push) begin
        o_stack_addr <= sp_r + CSPRG_ONE;
        o_stack_data <= i_push_data;
      end
    end
  end
  // ----------------------------------------
  // indirect pointer
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      dpl_r <= CSPRG_ZERO_RST;
      dph_r <= CSPRG_ZERO_RST;
    end else if (i_ptr_inc) begin
      {dph_r, dpl_r} <= ptr_inc_val;
    end else begin
      dpl_r <= m_dpl[7:0];
      dph_r <= m_dph[7:0];
    end
  end
  assign o_indirect_pointer = {dph_r, dpl_r};
  // ----------------------------------------
  // status word
  // ----------------------------------------
  // arithmetic flag results override a software write in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cy_r <= 1'b0;
      ac_r <= 1'b0;
      ov_r <= 1'b0;
    end else if (i_arith_upd) begin
      cy_r <= i_arith_cy;
      ac_r <= i_arith_ac;
      ov_r <= i_arith_ov;
    end else begin
      cy_r <= m_psw[CSPRG_CY_BIT];
      ac_r <= m_psw[CSPRG_AC_BIT];
      ov_r <= m_psw[CSPRG_OV_BIT];
    end
  end
  // user flags and bank select change only through writes
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      f0_r <= 1'b0;
      f1_r <= 1'b0;
      rs_r <= 2'b00;
    end else begin
      f0_r <= m_psw[CSPRG_F0_BIT];
      f1_r <= m_psw[CSPRG_F1_BIT];
      rs_r <= m_psw[CSPRG_RS_HI:CSPRG_RS_LO];
    end
  end
  // parity has no storage, so a written value simply has nowhere to go
  always_comb begin
    psw_view = CSPRG_ZERO_RST;
    psw_view[CSPRG_CY_BIT] = cy_r;
    psw_view[CSPRG_AC_BIT] = ac_r;
    psw_view[CSPRG_F0_BIT] = f0_r;
    psw_view[CSPRG_RS_HI:CSPRG_RS_LO] = rs_r;
    psw_view[CSPRG_OV_BIT] = ov_r;
    psw_view[CSPRG_F1_BIT] = f1_r;
    psw_view[CSPRG_PAR_BIT] = ^acc_r;
  end
  assign o_processor_status_word = psw_view;
  assign o_reg_addr = {3'b000, rs_r, i_reg_idx};
  // ----------------------------------------
  // accumulators
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      acc_r <= CSPRG_ZERO_RST;
    end else if (i_acc_we) begin
      acc_r <= i_acc_data;
    end else begin
      acc_r <= m_acc[7:0];
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      b_r <= CSPRG_ZERO_RST;
    end else if (i_b_we) begin
      b_r <= i_b_data;
    end else begin
      b_r <= m_b[7:0];
    end
  end
  assign o_stack_top_pointer = sp_r;
  assign o_primary_working_reg = acc_r;
  assign o_secondary_working_reg = b_r;
  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_sfr_rdata <= CSPRG_ZERO_RST;
      o_sfr_rd_hit <= 1'b0;
    end else begin
      o_sfr_rd_hit <= 1'b0;
      o_sfr_rdata <= CSPRG_ZERO_RST;
      if (i_sfr_rd) begin
        o_sfr_rd_hit <= 1'b1;
        case (i_sfr_addr)
          CSPRG_ADDR_SP: o_sfr_rdata <= sp_r;
          CSPRG_ADDR_DPL: o_sfr_rdata <= dpl_r;
          CSPRG_ADDR_DPH: o_sfr_rdata <= dph_r;
          CSPRG_ADDR_PSW: o_sfr_rdata <= psw_view;
          CSPRG_ADDR_ACC: o_sfr_rdata <= acc_r;
          CSPRG_ADDR_B: o_sfr_rdata <= b_r;
          default: o_sfr_rd_hit <= 1'b0;
        endcase
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_push_req;
    i_push;
  endsequence
  sequence s_push_done;
    ##1 (sp_r == $past(sp_r) + CSPRG_ONE) && o_stack_wr && (o_stack_addr == sp_r);
  endsequence
  property p_reset_vals;
    @(posedge i_clock) i_sys_rst |=> sp_r == CSPRG_SP_RST && acc_r == CSPRG_ZERO_RST
      && b_r == CSPRG_ZERO_RST && psw_view == CSPRG_ZERO_RST && o_indirect_pointer == 16'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_push;
    @(posedge i_clock) disable iff (i_sys_rst) s_push_req |-> s_push_done;
  endproperty
  a_push: assert property (p_push) else $error("push did not bump then write");
  property p_ptr_high;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_sfr_wr && i_sfr_addr == CSPRG_ADDR_DPH && !i_ptr_inc
      |=> o_indirect_pointer[15:8] == $past(i_sfr_wdata);
  endproperty
  a_ptr_high: assert property (p_ptr_high) else $error("pointer high byte wrong");
  property p_carry;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_arith_upd |=> o_processor_status_word[CSPRG_CY_BIT] == $past(i_arith_cy);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  property p_half;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_arith_upd |=> o_processor_status_word[CSPRG_AC_BIT] == $past(i_arith_ac);
  endproperty
  a_half: assert property (p_half) else $error("half carry flag wrong");
  property p_bank;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_reg_addr[7:3] == {3'b000, o_processor_status_word[CSPRG_RS_HI:CSPRG_RS_LO]};
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");
  property p_ovf;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_arith_upd |=> o_processor_status_word[CSPRG_OV_BIT] == $past(i_arith_ov);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  property p_parity;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_processor_status_word[CSPRG_PAR_BIT] == ^o_primary_working_reg;
  endproperty
  a_parity: assert property (p_parity) else $error("parity wrong");
  property p_user;
    @(posedge i_clock) disable iff (i_sys_rst)
      !i_sys_rst && !(i_sfr_wr && i_sfr_addr == CSPRG_ADDR_PSW)
      && !(i_bit_wr && i_bit_addr[7:3] == CSPRG_ADDR_PSW[7:3])
      |=> $stable(o_processor_status_word[CSPRG_F0_BIT]) && $stable(o_processor_status_word[CSPRG_F1_BIT]);
  endproperty
  a_user: assert property (p_user) else $error("user flag changed");
  property p_acc_wr;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_sfr_wr && i_sfr_addr == CSPRG_ADDR_ACC && !i_acc_we
      |=> o_primary_working_reg == $past(i_sfr_wdata);
  endproperty
  a_acc_wr: assert property (p_acc_wr) else $error("accumulator write lost");
  property p_b_wr;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_sfr_wr && i_sfr_addr == CSPRG_ADDR_B && !i_b_we
      |=> o_secondary_working_reg == $past(i_sfr_wdata);
  endproperty
  a_b_wr: assert property (p_b_wr) else $error("second accumulator write lost");
endmodule // csprg_regs

// ==== test/csprg_stack_ram.sv ====
// behavioural internal ram behind the stack write port
`timescale 1ns/1ps
module csprg_stack_ram (
  // clock
  input wire logic i_clock,
  // stack write from the register block
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_data,
  // the two stack slots above the reset pointer
  output logic [15:0] o_pair
);
  logic [7:0] mem_r [256];
  always_ff @(posedge i_clock) begin
    if (i_wr === 1'b1) begin
      mem_r[i_addr] <= i_data;
    end
  end
  assign o_pair = {mem_r[8'h08], mem_r[8'h09]};
endmodule // csprg_stack_ram

// ==== test/csprg_regs_bench.sv ====
// self-checking bench for the core status and pointer register block
`timescale 1ns/1ps
module csprg_regs_bench;
  import csprg_pkg::*;
  typedef struct {string nm; int sel; logic [16:0] exp;} csprg_note_s;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_bit_addr = 8'h00;
  logic [7:0] i_push_data = 8'h00, i_acc_data = 8'h00, i_b_data = 8'h00;
  logic i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_bit_wr = 1'b0, i_bit_wdata = 1'b0;
  logic i_push = 1'b0, i_pop = 1'b0, i_ptr_inc = 1'b0, i_arith_upd = 1'b0;
  logic i_arith_cy = 1'b0, i_arith_ac = 1'b0, i_arith_ov = 1'b0;
  logic i_acc_we = 1'b0, i_b_we = 1'b0;
  logic [2:0] i_reg_idx = 3'h0;
  logic [7:0] o_sfr_rdata, o_stack_addr, o_stack_data, o_stack_top_pointer;
  logic [7:0] o_processor_status_word, o_primary_working_reg, o_secondary_working_reg;
  logic [7:0] o_reg_addr;
  logic o_sfr_rd_hit, o_stack_wr;
  logic [15:0] o_indirect_pointer, ram_pair;
  int fails = 0;
  int compares = 0;
  int seed = 32'hd9027865;
  logic [31:0] r;
  csprg_note_s notes [$];
  always #12.5 i_clock = ~i_clock;
  csprg_regs dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_rd_hit(o_sfr_rd_hit), .i_bit_wr(i_bit_wr),
    .i_bit_addr(i_bit_addr), .i_bit_wdata(i_bit_wdata), .i_push(i_push),
    .i_push_data(i_push_data), .i_pop(i_pop), .i_ptr_inc(i_ptr_inc),
    .i_arith_upd(i_arith_upd), .i_arith_cy(i_arith_cy), .i_arith_ac(i_arith_ac),
    .i_arith_ov(i_arith_ov), .i_acc_we(i_acc_we), .i_acc_data(i_acc_data),
    .i_b_we(i_b_we), .i_b_data(i_b_data), .i_reg_idx(i_reg_idx), .o_stack_wr(o_stack_wr),
    .o_stack_addr(o_stack_addr), .o_stack_data(o_stack_data),
    .o_stack_top_pointer(o_stack_top_pointer), .o_indirect_pointer(o_indirect_pointer),
    .o_processor_status_word(o_processor_status_word),
    .o_primary_working_reg(o_primary_working_reg),
    .o_secondary_working_reg(o_secondary_working_reg), .o_reg_addr(o_reg_addr));
  csprg_stack_ram ram (.i_clock(i_clock), .i_wr(o_stack_wr), .i_addr(o_stack_addr),
    .i_data(o_stack_data), .o_pair(ram_pair));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input string nm, input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [16:0] seen(input int sel);
    case (sel)
      0: return {8'h00, o_sfr_rd_hit, o_sfr_rdata};
      1: return {9'h000, o_stack_top_pointer};
      2: return {1'b0, o_indirect_pointer};
      3: return {9'h000, o_processor_status_word};
      4: return {9'h000, o_primary_working_reg};
      5: return {9'h000, o_secondary_working_reg};
      6: return {9'h000, o_reg_addr};
      7: return {o_stack_wr, o_stack_addr, o_stack_data};
      8: return {1'b0, ram_pair};
      9: return {14'h0000, o_processor_status_word[7:6], o_processor_status_word[2]};
      default: return {16'h0000, o_processor_status_word[0]};
    endcase
  endfunction
  // outputs settle between edges, so notes are taken at the falling edge
  always @(negedge i_clock) begin
    while (notes.size() > 0) begin
      check(notes[0].nm, seen(notes[0].sel), notes[0].exp);
      void'(notes.pop_front());
    end
  end
  task automatic note(input string nm, input int sel, input logic [16:0] exp);
    notes.push_back('{nm, sel, exp});
  endtask
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clock);
    i_sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic hit, input logic [7:0] d);
    @(posedge i_clock);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_clock);
    i_sfr_rd <= 1'b0;
    note("read", 0, {8'h00, hit, d});
  endtask
  task automatic bitw(input logic [7:0] a, input logic v);
    @(posedge i_clock);
    i_bit_addr <= a;
    i_bit_wdata <= v;
    i_bit_wr <= 1'b1;
    @(posedge i_clock);
    i_bit_wr <= 1'b0;
  endtask
  task automatic acc_load(input logic [7:0] d);
    @(posedge i_clock);
    i_acc_data <= d;
    i_acc_we <= 1'b1;
    @(posedge i_clock);
    i_acc_we <= 1'b0;
  endtask
  task automatic arith(input logic [2:0] f);
    @(posedge i_clock);
    {i_arith_cy, i_arith_ac, i_arith_ov} <= f;
    i_arith_upd <= 1'b1;
    @(posedge i_clock);
    i_arith_upd <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(CSPRG_ADDR_SP, 1'b1, CSPRG_SP_RST);
    rd(CSPRG_ADDR_PSW, 1'b1, 8'h00);
    rd(CSPRG_ADDR_ACC, 1'b1, 8'h00);
    rd(CSPRG_ADDR_B, 1'b1, 8'h00);
    rd(8'h97, 1'b0, 8'h00);
    // two pushes back to back, then a pop
    @(posedge i_clock);
    i_push <= 1'b1;
    i_push_data <= 8'hAA;
    @(posedge i_clock);
    i_push_data <= 8'h5C;
    note("stack write", 7, {1'b1, 8'h08, 8'hAA});
    @(posedge i_clock);
    i_push <= 1'b0;
    i_pop <= 1'b1;
    note("stack write", 7, {1'b1, 8'h09, 8'h5C});
    @(posedge i_clock);
    i_pop <= 1'b0;
    note("stack ram", 8, 17'h0AA5C);
    note("stack pointer", 1, 17'h00008);
    wr(CSPRG_ADDR_DPL, 8'hFF);
    wr(CSPRG_ADDR_DPH, 8'h12);
    note("pointer", 2, 17'h012FF);
    @(posedge i_clock);
    i_ptr_inc <= 1'b1;
    @(posedge i_clock);
    i_ptr_inc <= 1'b0;
    note("pointer", 2, 17'h01300);
    rd(CSPRG_ADDR_DPH, 1'b1, 8'h13);
    for (int i = 0; i < 8; i++) begin
      arith(i[2:0]);
      note("arith flags", 9, {14'h0000, i[2:0]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(CSPRG_ADDR_PSW, {3'h0, i[1:0], 3'h0});
      r = $random(seed);
      i_reg_idx <= r[2:0];
      note("register address", 6, {9'h000, 3'h0, i[1:0], r[2:0]});
    end
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      acc_load(r[7:0]);
      note("parity", 10, {16'h0000, ^r[7:0]});
      note("accumulator", 4, {9'h000, r[7:0]});
    end
    acc_load(8'h03);
    wr(CSPRG_ADDR_PSW, 8'h01);
    note("status word", 3, 17'h00000);
    bitw(8'hD5, 1'b1);
    bitw(8'hD1, 1'b1);
    arith(3'h7);
    note("status word", 3, 17'h000E6);
    bitw(8'hE7, 1'b1);
    note("status word", 3, 17'h000E7);
    bitw(8'hF0, 1'b1);
    note("second accumulator", 5, 17'h00001);
    @(posedge i_clock);
    i_b_data <= 8'h3C;
    i_b_we <= 1'b1;
    @(posedge i_clock);
    i_b_we <= 1'b0;
    i_sys_rst <= 1'b1;
    note("second accumulator", 5, 17'h0003C);
    @(posedge i_clock);
    i_sys_rst <= 1'b0;
    note("stack pointer", 1, 17'h00007);
    note("status word", 3, 17'h00000);
    note("pointer", 2, 17'h00000);
    note("accumulator", 4, 17'h00000);
    repeat (3) @(posedge i_clock);
    finish_test();
  end
endmodule // csprg_regs_bench
